// ==== design/mmp_pkg.sv ====
// Constants and types for the monitor memory map block
package mmp_pkg;
    localparam logic [7:0] AUX_DEV     = 8'ha0;
    localparam logic [7:0] MAIN_DEV    = 8'ha2;
    localparam logic [7:0] CTRL_DEV    = 8'h00;
    localparam logic [7:0] LOC_CTRL    = 8'h00;
    localparam logic [7:0] LOC_SRAM    = 8'h60;
    localparam logic [7:0] LOC_RES_END = 8'h69;
    localparam logic [7:0] LOC_DONE    = 8'h6f;
    localparam logic [7:0] LOC_FLAG0   = 8'h70;
    localparam logic [7:0] LOC_FLAG1   = 8'h71;
    localparam logic [7:0] LOC_IEN     = 8'h74;
    localparam logic [7:0] LOC_TBL_SEL = 8'h7f;
    localparam logic [7:0] TSEL_LAST   = 8'h03;
    // Offsets inside table one (upper half, bit 7 dropped), then limit offsets inside each channel's lower block
    localparam logic [6:0] LOC_MAN0    = 7'h02;
    localparam logic [6:0] LOC_MAN1    = 7'h03;
    localparam logic [6:0] LOC_CFG     = 7'h09;
    localparam logic [6:0] LOC_ADDR    = 7'h0c;
    localparam logic [6:0] LIM_HI_MSB  = 7'h00;
    localparam logic [6:0] LIM_HI_LSB  = 7'h01;
    localparam logic [6:0] LIM_LO_MSB  = 7'h02;
    localparam logic [6:0] LIM_LO_LSB  = 7'h03;
    localparam int CFG_TEMP_INDEX_ENABLE = 7;
    localparam int CFG_SINGLE_ADDRESS    = 6;
    localparam int CFG_ADDR_FROM_NVM     = 5;
    localparam int CFG_MAIN_LOCK         = 1;
    localparam int CFG_AUX_LOCK          = 0;
    localparam logic [2:0] RG_LOW = 3'h0;
    localparam logic [2:0] RG_AUX = 3'h1;
    localparam logic [2:0] RG_T00 = 3'h2;
    localparam logic [2:0] RG_T1  = 3'h3;
    localparam logic [2:0] RG_T2  = 3'h4;
    localparam logic [2:0] RG_T3  = 3'h5;
    localparam int MEM_DEPTH = 768;
    localparam int DEV_LSB   = 10;
    localparam int LOC_LSB   = 2;
    localparam int NCH       = 5;
    localparam logic signed [8:0] TEMP_MIN = -9'sd40;
    localparam logic signed [8:0] TEMP_MAX = 9'sd102;
    localparam logic [6:0] LUT_LAST = 7'h47;
    localparam logic [6:0] LUT_NONE = 7'h7f;
    // Count weights for software scaling only; see R06
    localparam int  VCC_LSB_UV = 100;
    localparam real MON_LSB_UV = 38.147;
    typedef enum logic [2:0] {
        CH_TEMP  = 3'b000,
        CH_VCC   = 3'b001,
        CH_MON_A = 3'b010,
        CH_MON_B = 3'b011,
        CH_MON_C = 3'b100
    } mmp_chan_e;
    typedef enum logic {CV_START = 1'b0, CV_WAIT = 1'b1} mmp_cv_e;
    typedef struct packed {logic start; mmp_chan_e chan;} mmp_adc_req_s;
    typedef struct packed {logic done; logic [11:0] value;} mmp_adc_rsp_s;
    typedef struct packed {logic fault_drain_out; logic fault_oe; logic los_out; logic los_oe;} mmp_pins_s;
    typedef struct packed {logic [7:0] pos1; logic [7:0] pos0;} mmp_wiper_s;
endpackage

// ==== design/mmp_top.sv ====
// Monitor memory map, write protection and resistor lookup behind APB
// Notes on behaviour
// R01 - Each finished conversion sets that channel's conversion-done bit.
// R02 - Results read as 16-bit left-justified words, low four bits zero.
// R03 - Channels convert in round-robin order, each refreshed once per frame.
// R04 - Each result is compared with its high and low limits; alarm flags set.
// R05 - Temperature compares signed; other channels compare unsigned.
// R06 - Supply count weighs 100 uV, monitor inputs 38.147 uV.
// R07 - Auto mode looks up positions by temperature in 2-degree steps, clamped.
// R08 - With indexing off, positions come from table one bytes 82h and 83h.
// R09 - Dual mode answers A0h and main address A2h or table-one byte 8Ch.
// R10 - Single mode ignores A0h and shows extra table 00 through main.
// R11 - Locations 80h up only via main; table chosen by main byte 7Fh.
// R12 - Main writes outside table 00 blocked only when protect pin high and main lock set.
// R13 - Aux lock alone blocks aux writes; in single mode protects table 00.
// R14 - Both lock bits live in byte 89h and are written only through main.
// R15 - Main 6Ah to 7Fh is always writable; results 60h to 69h are read-only.
// R16 - Reserved volatile bytes work as scratchpad.
// R17 - Two open-drain buffers; the first also asserts on enabled alarms.
// R18 - Each channel has its own interrupt enable.
// R19 - Writes land only when the path is unprotected; read-only bytes ignore writes.
// R20 - Aux memory is invisible to upper tables but mapped as table 00 in dual mode.
// R21 - First four channels flag in byte 70h, third monitor in byte 71h.
// R22 - Nonvolatile writes commit only at the stop condition.
// R23 - Auto mode reloads positions when a temperature changes the index.
// R24 - Alarm flags stay set until software clears them.
`timescale 1ns/1ps
`default_nettype none
module mmp_top (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 protect_pin,
    input  wire logic                 buf_in1,
    input  wire logic                 buf_in2,
    input  wire mmp_pkg::mmp_adc_rsp_s adc_rsp,
    output var mmp_pkg::mmp_adc_req_s  adc_req,
    output var mmp_pkg::mmp_pins_s     pins,
    output var mmp_pkg::mmp_wiper_s    wiper
);
    import mmp_pkg::*;

    logic [7:0]  mem [0:MEM_DEPTH-1];
    logic [11:0] res [0:NCH-1];
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic [9:0]  flags;
    logic [4:0]  done;
    logic [4:0]  ien;
    logic        pend;
    logic [9:0]  pend_idx;
    logic [7:0]  pend_dat;
    mmp_cv_e     cv;
    logic [6:0]  lut_idx;

    logic [7:0]  dev;
    logic [7:0]  loc;
    logic [7:0]  cfg;
    logic [7:0]  tsel;
    logic [7:0]  main_addr;
    logic        temp_index_enable;
    logic        single_address_select;
    logic        main_addr_from_nvm;
    logic        aux_write_lock;
    logic        main_write_lock;
    logic        main_prot;
    logic        hit_ctrl;
    logic        hit_main;
    logic        hit_aux;
    logic        d_ok;
    logic        d_main;
    logic        d_nvm;
    logic        d_wok;
    logic [9:0]  d_idx;
    logic [7:0]  rd8;
    logic        wr;
    logic        nvm_wr;
    logic        ram_wr;
    logic        stop_wr;
    logic        err;

    always_comb dev = paddr[DEV_LSB +: 8];
    always_comb loc = paddr[LOC_LSB +: 8];
    always_comb cfg = mem[{RG_T1, LOC_CFG}]; // see R14
    always_comb tsel = mem[{RG_LOW, LOC_TBL_SEL[6:0]}];
    always_comb temp_index_enable = cfg[CFG_TEMP_INDEX_ENABLE];
    always_comb single_address_select = cfg[CFG_SINGLE_ADDRESS];
    always_comb main_addr_from_nvm = cfg[CFG_ADDR_FROM_NVM];
    always_comb aux_write_lock = cfg[CFG_AUX_LOCK];
    always_comb main_write_lock = cfg[CFG_MAIN_LOCK];
    always_comb main_prot = sync2[0] & main_write_lock; // see R12
    always_comb main_addr = main_addr_from_nvm ? mem[{RG_T1, LOC_ADDR}] : MAIN_DEV; // see R09

    // Address bit 0 (read/write) is ignored for main and aux
    always_comb hit_ctrl = (dev == CTRL_DEV) && (loc == LOC_CTRL);
    always_comb hit_main = !hit_ctrl && (dev[7:1] == main_addr[7:1]);
    always_comb hit_aux = !hit_ctrl && !hit_main && !single_address_select
                          && (dev[7:1] == AUX_DEV[7:1]); // see R09 see R10

    always_comb begin
        d_ok = 1'b0;
        d_main = 1'b0;
        d_nvm = 1'b0;
        d_wok = 1'b0;
        d_idx = 10'h000;
        if (hit_main) begin
            d_main = 1'b1;
            if (!loc[7]) begin
                d_ok = 1'b1;
                d_idx = {RG_LOW, loc[6:0]};
                d_nvm = loc < LOC_SRAM;
                // Results are read-only
                d_wok = d_nvm ? !main_prot : (loc > LOC_RES_END); // see R12 see R15 see R16 see R19
            end else if (tsel == 8'h00) begin
                d_ok = 1'b1;
                d_idx = {single_address_select ? RG_T00 : RG_AUX, loc[6:0]}; // see R10 see R20
                d_nvm = 1'b1;
                d_wok = !aux_write_lock; // see R13
            end else if (tsel <= TSEL_LAST) begin
                d_ok = 1'b1;
                d_idx = {3'(RG_T00 + tsel[2:0]), loc[6:0]}; // see R11
                d_nvm = 1'b1;
                d_wok = !main_prot; // see R12
            end
        end else if (hit_aux && !loc[7]) begin
            // Aux path never reaches the upper tables
            d_ok = 1'b1;
            d_idx = {RG_AUX, loc[6:0]}; // see R11 see R20
            d_nvm = 1'b1;
            d_wok = !aux_write_lock; // see R13
        end
    end

    always_comb begin
        rd8 = mem[d_idx];
        if (d_main && !loc[7] && loc >= LOC_SRAM) begin
            if (loc <= LOC_RES_END) begin
                rd8 = loc[0] ? {res[loc[3:1]][3:0], 4'h0} : res[loc[3:1]][11:4]; // see R02 see R05
            end else if (loc == LOC_DONE) begin
                rd8 = {3'h0, done};
            end else if (loc == LOC_FLAG0) begin
                rd8 = flags[9:2]; // see R21
            end else if (loc == LOC_FLAG1) begin
                rd8 = {flags[1:0], 6'h00}; // see R21
            end else if (loc == LOC_IEN) begin
                rd8 = {3'h0, ien};
            end
        end
    end

    always_comb wr = psel & penable & pready & pwrite;
    // Only one byte may await the stop; a second one is refused
    always_comb nvm_wr = wr & d_ok & d_wok & d_nvm & !pend; // see R19
    always_comb ram_wr = wr & d_ok & d_wok & !d_nvm;
    always_comb stop_wr = wr & hit_ctrl;
    always_comb err = !(d_ok | hit_ctrl) | (pwrite & d_ok & d_nvm & d_wok & pend);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & !pready;
            if (psel & penable & !pready) begin
                pslverr <= err;
                prdata <= hit_ctrl ? {15'h0000, pend, wiper} : (d_ok ? {24'h00_0000, rd8} : 32'h0000_0000);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
            pend_idx <= 10'h000;
            pend_dat <= 8'h00;
        end else if (nvm_wr) begin
            pend <= 1'b1;
            pend_idx <= d_idx;
            pend_dat <= pwdata[7:0];
        end else if (stop_wr) begin
            pend <= 1'b0; // see R22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (stop_wr && pend) begin
            mem[pend_idx] <= pend_dat; // see R22
        end else if (ram_wr) begin
            mem[d_idx] <= pwdata[7:0]; // see R15 see R16
        end
    end

    // Conversion sequencer
    mmp_chan_e   ch;
    logic        cv_done;
    logic [15:0] v16;
    logic [6:0]  lb;
    logic [15:0] lim_hi;
    logic [15:0] lim_lo;
    logic        over;
    logic        under;
    logic [9:0]  flag_set;
    logic [9:0]  fmask;
    logic [4:0]  done_set;
    logic signed [8:0] t;
    logic signed [8:0] t_ofs;
    logic [6:0]  new_idx;
    logic [7:0]  man0;
    logic [7:0]  man1;

    always_comb ch = adc_req.chan;
    always_comb cv_done = (cv == CV_WAIT) && adc_rsp.done;
    always_comb v16 = {adc_rsp.value, 4'h0};
    always_comb lb = {1'b0, ch, 3'b000};
    always_comb lim_hi = {mem[{RG_LOW, lb | LIM_HI_MSB}], mem[{RG_LOW, lb | LIM_HI_LSB}]};
    always_comb lim_lo = {mem[{RG_LOW, lb | LIM_LO_MSB}], mem[{RG_LOW, lb | LIM_LO_LSB}]};
    always_comb over = (ch == CH_TEMP) ? ($signed(v16) > $signed(lim_hi)) : (v16 > lim_hi); // see R04 see R05
    always_comb under = (ch == CH_TEMP) ? ($signed(v16) < $signed(lim_lo)) : (v16 < lim_lo); // see R04 see R05

    always_comb begin
        flag_set = 10'h000;
        done_set = 5'h00;
        fmask = 10'h000;
        for (int k = 0; k < NCH; k++) begin
            fmask[9-2*k] = ien[k]; // see R18
            fmask[8-2*k] = ien[k];
            if (cv_done && ch == 3'(k)) begin
                flag_set[9-2*k] = over; // see R04 see R21
                flag_set[8-2*k] = under;
                done_set[k] = 1'b1; // see R01
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cv <= CV_START;
            adc_req <= '0;
        end else begin
            unique case (cv)
                CV_START: begin
                    adc_req.start <= 1'b1;
                    cv <= CV_WAIT;
                end
                CV_WAIT: begin
                    adc_req.start <= 1'b0;
                    if (adc_rsp.done) begin
                        adc_req.chan <= (ch == CH_MON_C) ? CH_TEMP : mmp_chan_e'(ch + 3'h1); // see R03
                        cv <= CV_START;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                res[i] <= 12'h000;
            end
        end else if (cv_done) begin
            res[ch] <= adc_rsp.value; // see R02 see R03
        end
    end

    // A hardware set beats a same-cycle write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 10'h000;
            done <= 5'h00;
            ien <= 5'h1f;
        end else begin
            flags[9:2] <= ((ram_wr && d_main && loc == LOC_FLAG0) ? pwdata[7:0] : flags[9:2]) | flag_set[9:2]; // see R24
            flags[1:0] <= ((ram_wr && d_main && loc == LOC_FLAG1) ? pwdata[7:6] : flags[1:0]) | flag_set[1:0]; // see R24
            done <= ((ram_wr && d_main && loc == LOC_DONE) ? pwdata[4:0] : done) | done_set; // see R01
            if (ram_wr && d_main && loc == LOC_IEN) begin
                ien <= pwdata[4:0]; // see R18
            end
        end
    end

    // Resistor positions
    always_comb t = {adc_rsp.value[11], adc_rsp.value[11:4]};
    always_comb t_ofs = t - TEMP_MIN;
    always_comb man0 = mem[{RG_T1, LOC_MAN0}];
    always_comb man1 = mem[{RG_T1, LOC_MAN1}];
    always_comb begin
        if (t < TEMP_MIN) begin
            new_idx = 7'h00; // see R07
        end else if (t > TEMP_MAX) begin
            new_idx = LUT_LAST; // see R07
        end else begin
            new_idx = t_ofs[7:1]; // see R07
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wiper <= '0;
            lut_idx <= LUT_NONE;
        end else if (!temp_index_enable) begin
            wiper.pos0 <= man0; // see R08
            wiper.pos1 <= man1;
            lut_idx <= LUT_NONE;
        end else if (cv_done && ch == CH_TEMP && new_idx != lut_idx) begin
            lut_idx <= new_idx; // see R23
            wiper.pos0 <= mem[{RG_T2, new_idx}]; // see R07
            wiper.pos1 <= mem[{RG_T3, new_idx}];
        end
    end

    // Buffers; pins cross into pclk through two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            pins <= '0;
        end else begin
            sync1 <= {buf_in2, buf_in1, protect_pin};
            sync2 <= sync1;
            pins.fault_oe <= !sync2[1] | (|(flags & fmask)); // see R17
            pins.los_oe <= !sync2[2]; // see R17
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_main_locked: assert property (wr && hit_main && !loc[7] && d_nvm && main_prot |=> $stable(pend)) // see R12
        else $error("protected main write was staged");
    a_main_open: assert property (wr && hit_main && !loc[7] && d_nvm && !main_prot && !pend
        |=> pend && pend_dat == $past(pwdata[7:0])) // see R12
        else $error("open main write not staged");
    a_aux_locked: assert property (wr && hit_aux && aux_write_lock |=> $stable(pend)) // see R13
        else $error("locked aux write was staged");
    a_sram_open: assert property (wr && hit_main && loc == LOC_TBL_SEL |=> tsel == $past(pwdata[7:0])) // see R15
        else $error("volatile byte not written");
    a_stop_commit: assert property (stop_wr && pend |=> !pend && mem[$past(pend_idx)] == $past(pend_dat)) // see R22
        else $error("stop did not commit byte");
    a_done_bit: assert property (cv_done |=> done[$past(ch)]) // see R01
        else $error("conversion done bit not set");
    a_flag_sticky: assert property (flags[9] && !(ram_wr && d_main && loc == LOC_FLAG0) |=> flags[9]) // see R24
        else $error("alarm flag dropped by itself");
    a_fault_drive: assert property (|(flags & fmask) |=> pins.fault_oe) // see R17
        else $error("fault output not driven on alarm");
    a_round_robin: assert property (cv_done && ch == CH_MON_C |=> adc_req.chan == CH_TEMP ##1 adc_req.start) // see R03
        else $error("sequence did not wrap");
    a_manual_pos: assert property (!temp_index_enable |=> wiper.pos0 == $past(man0) && wiper.pos1 == $past(man1)) // see R08
        else $error("manual position mismatch");
    a_index_clamp: assert property (cv_done && ch == CH_TEMP && temp_index_enable && t < TEMP_MIN
        && $stable(temp_index_enable) |=> lut_idx == 7'h00) // see R07
        else $error("cold index not clamped");
    a_left_just: assert property (pready && psel && !pwrite && d_main && !loc[7] && loc >= LOC_SRAM
        && loc <= LOC_RES_END && loc[0] |-> prdata[3:0] == 4'h0) // see R02
        else $error("result low nibble not zero");
    a_single_no_aux: assert property (pready && psel && single_address_select && dev == AUX_DEV
        && main_addr[7:1] != AUX_DEV[7:1] |-> pslverr) // see R10
        else $error("aux address answered in single mode");

    c_commit: cover property (stop_wr && pend);
    c_alarm: cover property (|flag_set);
    c_reload: cover property (temp_index_enable && cv_done && ch == CH_TEMP && new_idx != lut_idx);
    c_aux_write: cover property (wr && hit_aux && !aux_write_lock);
endmodule
`default_nettype wire

// ==== bench/mmp_adc_model.sv ====
// Converter model on the far side of the monitor block
`timescale 1ns/1ps
`default_nettype none
module mmp_adc_model (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire mmp_pkg::mmp_adc_req_s adc_req,
    output var mmp_pkg::mmp_adc_rsp_s  adc_rsp
);
    import mmp_pkg::*;
    logic [11:0] val [NCH];
    logic        slow = 1'b1;
    int          conv_n = 0;
    logic        busy;
    logic [3:0]  cnt;
    mmp_chan_e   ch;
    // Value toggles between answers, so a late sample fails
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            adc_rsp <= '0;
        end else begin
            adc_rsp.done <= 1'b0;
            adc_rsp.value <= ~adc_rsp.value;
            if (adc_req.start) begin
                busy <= 1'b1;
                cnt <= slow ? 4'h7 : 4'h0;
                ch <= adc_req.chan;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                adc_rsp.done <= 1'b1;
                adc_rsp.value <= val[ch];
                conv_n <= conv_n + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/monitor_memory_map_protect_bench.sv ====
// Self-checking bench for the monitor memory map block
`timescale 1ns/1ps
`default_nettype none
module monitor_memory_map_protect_bench;
    import mmp_pkg::*;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]  paddr = '0, pwdata = '0, prdata, rdv, lim;
    logic         pready, pslverr, err, protect_pin = 1'b0, buf_in1 = 1'b1, buf_in2 = 1'b1;
    mmp_adc_req_s adc_req;
    mmp_adc_rsp_s adc_rsp;
    mmp_pins_s    pins;
    mmp_wiper_s   wiper;
    int           bad_count = 0, checks_done = 0, cycles = 0, seed = 32'h8faa, idx;
    logic [7:0]   mem [1280] = '{default: 8'h00};
    logic [15:0]  exp_fl = '0;
    logic [7:0]   main_dev = MAIN_DEV;
    logic [2:0]   exp_ch = 3'h0;
    logic [11:0]  flag_t [4] = '{12'hd00, 12'hf60, 12'h7f0, 12'h600};
    logic [11:0]  auto_t [4] = '{12'hd00, 12'hda0, 12'h190, 12'h7f0};
    logic [7:0]   ien_t [4] = '{8'h00, 8'h08, 8'h04, 8'h1f};
    always #5 pclk = ~pclk;
    mmp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .protect_pin(protect_pin),
        .buf_in1(buf_in1), .buf_in2(buf_in2), .adc_rsp(adc_rsp), .adc_req(adc_req), .pins(pins), .wiper(wiper));
    mmp_adc_model adc (.pclk(pclk), .presetn(presetn), .adc_req(adc_req), .adc_rsp(adc_rsp));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [7:0] dev, loc, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0, dev, loc, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic int key(input logic [7:0] dev, loc);
        if (!loc[7]) return (dev == AUX_DEV) ? 256 + loc : loc;
        return (mem[127] == 8'h00) ? 256 + loc[6:0] : (mem[127] + 1) * 256 + loc;
    endfunction
    function automatic logic locked(input logic [7:0] dev, loc);
        if (dev == AUX_DEV || (loc[7] && mem[127] == 8'h00)) return mem[16'h289][0];
        return protect_pin & mem[16'h289][1];
    endfunction
    task automatic nv_wr(input logic [7:0] dev, loc, d);
        apb(1'b1, dev, loc, d);
        chk_bit(err, 1'b0);
        if (!locked(dev, loc)) mem[key(dev, loc)] = d;
        apb(1'b1, CTRL_DEV, 8'h00, 8'h00);
    endtask
    task automatic vol_wr(input logic [7:0] loc, d);
        apb(1'b1, main_dev, loc, d);
        mem[loc] = d;
    endtask
    task automatic rd(input logic [7:0] dev, loc, exp);
        apb(1'b0, dev, loc, 8'h00);
        chk_word(rdv, {24'h0, exp});
    endtask
    function automatic logic [15:0] calc();
        logic [15:0] f, r, hi, lo;
        f = '0;
        for (int c = 0; c < NCH; c++) begin
            r = {adc.val[c], 4'h0};
            hi = {mem[8*c], mem[8*c+1]};
            lo = {mem[8*c+2], mem[8*c+3]};
            f[15-2*c] = (c != 0) ? r > hi : $signed(r) > $signed(hi);
            f[14-2*c] = (c != 0) ? r < lo : $signed(r) < $signed(lo);
        end
        return f;
    endfunction
    // Two frames, so all channels hold the present values
    task automatic settle();
        int t0;
        t0 = adc.conv_n;
        while (adc.conv_n < t0 + 10) @(posedge pclk);
        exp_fl |= calc();
    endtask
    task automatic clr();
        vol_wr(LOC_FLAG0, 8'h00);
        vol_wr(LOC_FLAG1, 8'h00);
        exp_fl = '0;
    endtask
    task automatic flg_chk();
        rd(main_dev, LOC_FLAG0, exp_fl[15:8]);
        rd(main_dev, LOC_FLAG1, exp_fl[7:0]);
    endtask
    task automatic pins_chk(input logic in1, in2);
        logic [4:0] hit;
        @(posedge pclk);
        buf_in1 <= in1;
        buf_in2 <= in2;
        repeat (4) @(posedge pclk);
        for (int c = 0; c < NCH; c++) hit[c] = exp_fl[15-2*c] | exp_fl[14-2*c];
        chk_bit(pins.fault_oe, !in1 || (hit & mem[16'h74][4:0]) != 5'h0);
        chk_bit(pins.los_oe, !in2);
        chk_bit(pins.fault_drain_out | pins.los_out, 1'b0);
    endtask
    task automatic wip_chk(input logic [7:0] p0, p1);
        repeat (3) @(posedge pclk);
        chk_word({16'h0, wiper}, {16'h0, p1, p0});
        apb(1'b0, CTRL_DEV, 8'h00, 8'h00);
        chk_word(rdv, {16'h0, p1, p0});
    endtask
    task automatic setpin(input logic v);
        protect_pin <= v;
        repeat (3) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (presetn && adc_req.start) begin
            chk_word(32'(adc_req.chan), 32'(exp_ch));
            exp_ch <= (exp_ch == 3'h4) ? 3'h0 : exp_ch + 3'h1;
        end
        if (cycles > 60000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        for (int c = 0; c < NCH; c++) adc.val[c] = 12'($random(seed));
        mem[16'h74] = 8'h1f;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(main_dev, LOC_IEN, 8'h1f);
        rd(main_dev, LOC_FLAG0, 8'h00);
        adc.slow = 1'b0;
        settle();
        apb(1'b1, main_dev, 8'h60, 8'hff);
        for (int c = 0; c < NCH; c++) begin
            rd(main_dev, 8'h60 + 8'(2 * c), adc.val[c][11:4]);
            rd(main_dev, 8'h61 + 8'(2 * c), {adc.val[c][3:0], 4'h0});
        end
        rd(main_dev, LOC_DONE, 8'h1f);
        $display("test results done");
        adc.slow = 1'b1;
        adc.val[1] = 12'hd00;
        adc.val[2] = 12'h050;
        adc.val[3] = 12'h800;
        adc.val[4] = 12'($random(seed));
        for (int c = 0; c < NCH; c++) begin
            lim = (c != 0) ? 32'hc000_1000 : 32'h5000_d800;
            for (int b = 0; b < 4; b++) nv_wr(main_dev, 8'(8 * c + b), lim[31-8*b -: 8]);
        end
        clr();
        settle();
        foreach (flag_t[i]) begin
            adc.val[0] = flag_t[i];
            settle();
            flg_chk();
            clr();
            settle();
            flg_chk();
        end
        $display("test flags done");
        foreach (ien_t[i]) begin
            vol_wr(LOC_IEN, ien_t[i]);
            pins_chk(1'b1, 1'($random(seed)));
            pins_chk(1'($random(seed)), 1'($random(seed)));
        end
        $display("test pins done");
        vol_wr(LOC_TBL_SEL, 8'h01);
        nv_wr(main_dev, 8'h82, 8'($random(seed)));
        nv_wr(main_dev, 8'h83, 8'($random(seed)));
        wip_chk(mem[16'h282], mem[16'h283]);
        nv_wr(main_dev, 8'h89, 8'h80);
        foreach (auto_t[i]) begin
            idx = $signed(auto_t[i][11:4]);
            idx = (idx < -40) ? 0 : (idx > 102) ? 71 : (idx + 40) / 2;
            vol_wr(LOC_TBL_SEL, 8'h02);
            nv_wr(main_dev, 8'(128 + idx), 8'($random(seed)));
            vol_wr(LOC_TBL_SEL, 8'h03);
            nv_wr(main_dev, 8'(128 + idx), 8'($random(seed)));
            adc.val[0] = auto_t[i];
            settle();
            wip_chk(mem[896 + idx], mem[1152 + idx]);
        end
        $display("test wiper done");
        for (int i = 0; i < 4; i++) begin
            setpin(1'b0);
            vol_wr(LOC_TBL_SEL, 8'h01);
            nv_wr(main_dev, 8'h89, (i < 2) ? 8'h82 : 8'h81);
            setpin(i[0] == 1'b0);
            nv_wr(main_dev, 8'h30, 8'($random(seed)));
            nv_wr(AUX_DEV, 8'h10, 8'($random(seed)));
            vol_wr(8'h6a, 8'($random(seed)));
            rd(main_dev, 8'h30, mem[16'h30]);
            rd(AUX_DEV, 8'h10, mem[16'h110]);
            rd(main_dev, 8'h6a, mem[16'h6a]);
        end
        $display("test protect done");
        setpin(1'b0);
        nv_wr(main_dev, 8'h89, 8'h80);
        apb(1'b1, main_dev, 8'h31, 8'h5a);
        apb(1'b1, main_dev, 8'h32, 8'h33);
        chk_bit(err, 1'b1);
        rd(main_dev, 8'h31, mem[16'h31]);
        apb(1'b1, CTRL_DEV, 8'h00, 8'h00);
        rd(main_dev, 8'h31, 8'h5a);
        apb(1'b1, AUX_DEV, 8'h89, 8'h00);
        chk_bit(err, 1'b1);
        vol_wr(LOC_TBL_SEL, 8'h05);
        apb(1'b0, main_dev, 8'h80, 8'h00);
        chk_bit(err, 1'b1);
        vol_wr(LOC_TBL_SEL, 8'h01);
        nv_wr(main_dev, 8'h8c, 8'hb4);
        nv_wr(main_dev, 8'h89, 8'he0);
        apb(1'b0, AUX_DEV, 8'h10, 8'h00);
        chk_bit(err, 1'b1);
        apb(1'b0, MAIN_DEV, 8'h30, 8'h00);
        chk_bit(err, 1'b1);
        main_dev = 8'hb4;
        rd(main_dev, 8'h30, mem[16'h30]);
        $display("test address done");
        complete_run();
    end
endmodule
`default_nettype wire
